// >>> core/comm_module_timer_quad.sv
`timescale 1ns/100ps
`include "timer_quad_defines.svh"
module comm_module_timer_quad #(
  parameter int TMR_WIDTH = 16
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Input pins
  input wire logic [3:0] TIMER_EXT_IN,
  input wire logic GATE_PIN_A,
  input wire logic GATE_PIN_B,
  input wire logic [9:0] CLOCK_IN,
  input wire logic DEDICATED_TIMER_CLOCK_PIN,
  // Output pins
  output logic [3:0] TIMER_MATCH_OUT,
  output logic [3:0] TIMER_MATCH_OUT_OE_N,
  output logic [7:0] RATE_GEN_OUT,
  output logic [7:0] RATE_GEN_OUT_OE_N,
  // Internal clock enables
  output logic [3:0] CTRL_CLK_TICK,
  output logic SYS_TMR_TICK,
  // Interrupt
  output logic IRQ
);
  import timer_quad_pkg::*;

  localparam int NT = `NUM_TIMERS;
  localparam int NG = `NUM_RATE_GEN;
  localparam int NC = `NUM_CLK_IN;
  localparam int NR = `NUM_ROUTES;
  localparam int NE = `NUM_EVENTS;
  localparam int NSRC = NC + NG;

  // ****************************************
  // Registers and wires
  // ****************************************
  logic [`GCR_MSB:0] gcr_ff;
  logic [`PORT_MSB:0] port_ff;
  logic [`ROUTE_MSB:0] route_ff;
  logic [NE-1:0] int_stat_ff;
  logic [NE-1:0] int_en_ff;
  logic [`MODE_MSB:0] mode_ff [NT];
  logic [TMR_WIDTH-1:0] ref_ff [NT];
  logic [`RG_MSB:0] rg_ff [NG];
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wr_go;
  logic [NE-1:0] int_clr;
  logic [3:0] div16_ff;
  logic div16_tick;
  logic [NC-1:0] clk_prev_ff;
  logic [NC-1:0] clk_pin;
  logic [NC-1:0] clk_rise;
  logic ded_prev_ff;
  logic ded_rise;
  logic [NT-1:0] ext_pin;
  logic [NT-1:0] ext_prev_ff;
  logic [NT-1:0] ext_rise;
  logic [NT-1:0] gate_lvl;
  logic [NT-1:0] gate_prev_ff;
  logic [NT-1:0] tmr_tick;
  logic [NT-1:0] tmr_run;
  logic [NT-1:0] tmr_restart;
  logic [NT-1:0] tmr_load;
  logic [NT-1:0] match;
  logic [NT-1:0] cap_evt;
  logic [NT-1:0] out_lvl;
  logic [TMR_WIDTH-1:0] count [NT];
  logic [TMR_WIDTH-1:0] cap_val [NT];
  logic [NG-1:0] rg_src;
  logic [NG-1:0] rg_tick;
  logic [NG-1:0] rg_wave;
  logic [NSRC-1:0] bank_src;
  logic [3:0] tmr_out_ff;
  logic [3:0] tmr_oe_n_ff;
  logic [7:0] rg_out_ff;
  logic [7:0] rg_oe_n_ff;
  logic [3:0] ctrl_tick_ff;
  logic sys_tick_ff;
  logic irq_ff;

  // ****************************************
  // Address decode helpers
  // ****************************************
  function automatic logic in_tmr(input logic [7:0] a);
    return (a & `TMR_REGION_MASK) == `OFS_TMR_BASE;
  endfunction

  function automatic logic in_rg(input logic [7:0] a);
    return (a & `RG_REGION_MASK) == `OFS_RG_BASE;
  endfunction

  // Bank source picker; codes past the last source give no clock
  function automatic logic pick(input logic [NSRC-1:0] src, input logic [`ROUTE_W-1:0] sel);
    return (int'(sel) < NSRC) ? src[sel] : 1'b0;
  endfunction

  // ****************************************
  // APB slave
  // ****************************************
  assign wr_go = PSEL & PENABLE & PWRITE & pready_ff;
  assign int_clr = (wr_go && PADDR == `OFS_INT_CLR) ? PWDATA[NE-1:0] : '0;

  // Read mux; the clear register is write-only and reads as zero
  always_comb begin
    rd_data = `RST_ZERO;
    rd_ok = 1'b1;
    if (in_tmr(PADDR)) begin
      case (PADDR[`TMR_FLD])
        `FLD_MODE: rd_data[`MODE_MSB:0] = mode_ff[PADDR[`TMR_IDX]];
        `FLD_REF: rd_data[TMR_WIDTH-1:0] = ref_ff[PADDR[`TMR_IDX]];
        `FLD_CNT: rd_data[TMR_WIDTH-1:0] = count[PADDR[`TMR_IDX]];
        default: rd_data[TMR_WIDTH-1:0] = cap_val[PADDR[`TMR_IDX]];
      endcase
    end else if (in_rg(PADDR)) begin
      rd_data[`RG_MSB:0] = rg_ff[PADDR[`RG_IDX]];
    end else begin
      case (PADDR)
        `OFS_GCR: rd_data[`GCR_MSB:0] = gcr_ff;
        `OFS_PORT: rd_data[`PORT_MSB:0] = port_ff;
        `OFS_ROUTE: rd_data[`ROUTE_MSB:0] = route_ff;
        `OFS_INT_STAT: rd_data[NE-1:0] = int_stat_ff;
        `OFS_INT_CLR: rd_data = `RST_ZERO;
        `OFS_INT_EN: rd_data[NE-1:0] = int_en_ff;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // Answer one cycle after setup: every access has exactly one access cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pready_ff <= 1'b0;
      prdata_ff <= `RST_ZERO;
      pslverr_ff <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      pready_ff <= 1'b1;
      prdata_ff <= PWRITE ? `RST_ZERO : rd_data;
      pslverr_ff <= ~rd_ok;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  // Global, port and route registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      gcr_ff <= '0;
      port_ff <= '0;
      route_ff <= '0;
      int_en_ff <= '0;
    end else if (wr_go) begin
      case (PADDR)
        `OFS_GCR: gcr_ff <= PWDATA[`GCR_MSB:0];
        `OFS_PORT: port_ff <= PWDATA[`PORT_MSB:0];
        `OFS_ROUTE: route_ff <= PWDATA[`ROUTE_MSB:0];
        `OFS_INT_EN: int_en_ff <= PWDATA[NE-1:0];
        default: ;
      endcase
    end
  end

  // Per-timer mode and reference registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < NT; i++) begin
        mode_ff[i] <= '0;
        ref_ff[i] <= '0;
      end
    end else if (wr_go && in_tmr(PADDR)) begin
      if (PADDR[`TMR_FLD] == `FLD_MODE) begin
        mode_ff[PADDR[`TMR_IDX]] <= PWDATA[`MODE_MSB:0];
      end
      if (PADDR[`TMR_FLD] == `FLD_REF) begin
        ref_ff[PADDR[`TMR_IDX]] <= PWDATA[TMR_WIDTH-1:0];
      end
    end
  end

  // Rate generator setup registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int g = 0; g < NG; g++) begin
        rg_ff[g] <= '0;
      end
    end else if (wr_go && in_rg(PADDR)) begin
      rg_ff[PADDR[`RG_IDX]] <= PWDATA[`RG_MSB:0];
    end
  end

  // ****************************************
  // Pin conditioning
  // ****************************************
  // inert disabled inputs
  assign clk_pin = CLOCK_IN & port_ff[`PORT_CLK_EN];
  assign ext_pin = TIMER_EXT_IN & port_ff[`PORT_IN_EN];
  assign clk_rise = clk_pin & ~clk_prev_ff;
  assign ext_rise = ext_pin & ~ext_prev_ff;
  assign ded_rise = DEDICATED_TIMER_CLOCK_PIN & ~ded_prev_ff;

  // Edge history of the clocking pins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      clk_prev_ff <= '0;
      ext_prev_ff <= '0;
      ded_prev_ff <= 1'b0;
    end else begin
      clk_prev_ff <= clk_pin;
      ext_prev_ff <= ext_pin;
      ded_prev_ff <= DEDICATED_TIMER_CLOCK_PIN;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div16_ff <= '0;
    end else begin
      div16_ff <= div16_ff + 1'b1;
    end
  end
  assign div16_tick = (div16_ff == `DIV16_LAST);

  // ****************************************
  // Timers
  // ****************************************
  // Gate pins are active low; an unselected or disabled gate reads inactive high
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      // pin A low pair, B high pair
      if (!gcr_ff[i]) begin
        gate_lvl[i] = 1'b1;
      end else if (i < NT / 2) begin
        gate_lvl[i] = GATE_PIN_A | ~port_ff[`PORT_GATE_A_EN];
      end else begin
        gate_lvl[i] = GATE_PIN_B | ~port_ff[`PORT_GATE_B_EN];
      end
    end
  end

  // Gate history for the restart edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      gate_prev_ff <= '1;
    end else begin
      gate_prev_ff <= gate_lvl;
    end
  end

  // Tick, run, restart and load per timer
  always_comb begin
    for (int i = 0; i < NT; i++) begin
      case (src_sel_t'(mode_ff[i][`MODE_SRC]))
        SRC_PARTNER: tmr_tick[i] = match[i ^ 1];
        SRC_SYSCLK: tmr_tick[i] = 1'b1;
        SRC_DIV16: tmr_tick[i] = div16_tick;
        SRC_PIN: tmr_tick[i] = ext_rise[i];
        default: tmr_tick[i] = 1'b0;
      endcase
      tmr_run[i] = mode_ff[i][`MODE_EN] &
        ((gate_mode_t'(mode_ff[i][`MODE_GATE]) != GATE_LEVEL) | ~gate_lvl[i]);
      tmr_restart[i] = (gate_mode_t'(mode_ff[i][`MODE_GATE]) == GATE_RESTART) &
        gate_prev_ff[i] & ~gate_lvl[i];
      tmr_load[i] = wr_go & in_tmr(PADDR) & (PADDR[`TMR_FLD] == `FLD_CNT) &
        (PADDR[`TMR_IDX] == i[1:0]);
    end
  end

  for (genvar i = 0; i < NT; i++) begin : g_tmr
    timer_unit #(
      .WIDTH(TMR_WIDTH)
    ) u_tmr (
      .clk(CLK),
      .rst(RST),
      .tick(tmr_tick[i]),
      .run(tmr_run[i]),
      .restart(tmr_restart[i]),
      .load(tmr_load[i]),
      .load_val(PWDATA[TMR_WIDTH-1:0]),
      .ref_val(ref_ff[i]),
      .out_toggle(mode_ff[i][`MODE_TOGGLE]),
      .ref_restart(mode_ff[i][`MODE_REF_RST]),
      .cap_in(ext_pin[i]),
      .cap_edge(edge_sel_t'(mode_ff[i][`MODE_EDGE])),
      .count_ff(count[i]),
      .cap_ff(cap_val[i]),
      .match_ff(match[i]),
      .cap_evt_ff(cap_evt[i]),
      .out_ff(out_lvl[i])
    );
  end

  // ****************************************
  // Rate generators and clock bank
  // ****************************************
  // fifth input feeds first generator
  always_comb begin
    rg_src = '1;
    rg_src[0] = gcr_ff[`GCR_FIFTH_SEL] ? clk_rise[`FIFTH_CLK] : 1'b1;
  end

  for (genvar g = 0; g < NG; g++) begin : g_rg
    rate_gen #(
      .WIDTH(16)
    ) u_rg (
      .clk(CLK),
      .rst(RST),
      .src_tick(rg_src[g]),
      .enable(rg_ff[g][`RG_EN]),
      .divisor(rg_ff[g][`RG_DIV]),
      .tick_ff(rg_tick[g]),
      .wave_ff(rg_wave[g])
    );
  end

  assign bank_src = {rg_tick, clk_rise};

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_tick_ff <= '0;
    end else begin
      for (int r = 0; r < NR; r++) begin
        ctrl_tick_ff[r] <= pick(bank_src, route_ff[r*`ROUTE_W +: `ROUTE_W]);
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sys_tick_ff <= 1'b0;
    end else begin
      sys_tick_ff <= gcr_ff[`GCR_DED_SEL] ? ded_rise : rg_tick[0];
    end
  end

  // ****************************************
  // Output pins
  // ****************************************
  // undriven when not selected
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tmr_out_ff <= '1;
      tmr_oe_n_ff <= '1;
      rg_out_ff <= '0;
      rg_oe_n_ff <= '1;
    end else begin
      tmr_out_ff <= out_lvl | ~port_ff[`PORT_OUT_EN];
      tmr_oe_n_ff <= ~port_ff[`PORT_OUT_EN];
      for (int g = 0; g < NG; g++) begin
        rg_out_ff[g] <= rg_wave[g] & rg_ff[g][`RG_PIN];
        rg_oe_n_ff[g] <= ~rg_ff[g][`RG_PIN];
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  // A new event in the clearing cycle survives: set beats clear
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      int_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      int_stat_ff <= (int_stat_ff & ~int_clr) | {cap_evt, match};
      irq_ff <= |(int_stat_ff & int_en_ff);
    end
  end

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign TIMER_MATCH_OUT = tmr_out_ff;
  assign TIMER_MATCH_OUT_OE_N = tmr_oe_n_ff;
  assign RATE_GEN_OUT = rg_out_ff;
  assign RATE_GEN_OUT_OE_N = rg_oe_n_ff;
  assign CTRL_CLK_TICK = ctrl_tick_ff;
  assign SYS_TMR_TICK = sys_tick_ff;
  assign IRQ = irq_ff;
endmodule // comm_module_timer_quad

// >>> core/rate_gen.sv
`timescale 1ns/100ps
module rate_gen #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic src_tick,
  input wire logic enable,
  input wire logic [WIDTH-1:0] divisor,
  // Results
  output logic tick_ff,
  output logic wave_ff
);
  import timer_quad_pkg::*;
  logic [WIDTH-1:0] cnt_ff;

  // Divide source ticks by divisor+1; wave toggles on every terminal count (>= survives a lowered divisor)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
      wave_ff <= 1'b0;
    end else if (!enable) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (src_tick && cnt_ff >= divisor) begin
      cnt_ff <= '0;
      tick_ff <= 1'b1;
      wave_ff <= ~wave_ff;
    end else begin
      if (src_tick) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
      tick_ff <= 1'b0;
    end
  end
endmodule // rate_gen

// >>> core/timer_quad_defines.svh
`ifndef TIMER_QUAD_DEFINES_SVH
`define TIMER_QUAD_DEFINES_SVH

// ****************************************
// Sizes
// ****************************************
`define NUM_TIMERS 4
`define NUM_RATE_GEN 8
`define NUM_CLK_IN 10
`define NUM_ROUTES 4
`define NUM_EVENTS 8
`define FIFTH_CLK 4

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_GCR 8'h00
`define OFS_PORT 8'h04
`define OFS_ROUTE 8'h08
`define OFS_INT_STAT 8'h10
`define OFS_INT_CLR 8'h14
`define OFS_INT_EN 8'h18
`define OFS_TMR_BASE 8'h40
`define TMR_REGION_MASK 8'hC0
`define TMR_IDX 5:4
`define TMR_FLD 3:2
`define FLD_MODE 2'h0
`define FLD_REF 2'h1
`define FLD_CNT 2'h2
`define FLD_CAP 2'h3
`define OFS_RG_BASE 8'h80
`define RG_REGION_MASK 8'hE0
`define RG_IDX 4:2

// ****************************************
// Fields and reset values
// ****************************************
`define GCR_MSB 9
`define GCR_GATE_SEL 3:0
`define GCR_FIFTH_SEL 8
`define GCR_DED_SEL 9
`define PORT_MSB 19
`define PORT_OUT_EN 3:0
`define PORT_IN_EN 7:4
`define PORT_GATE_A_EN 8
`define PORT_GATE_B_EN 9
`define PORT_CLK_EN 19:10
`define ROUTE_MSB 19
`define ROUTE_W 5
`define MODE_MSB 8
`define MODE_SRC 1:0
`define MODE_TOGGLE 2
`define MODE_EDGE 4:3
`define MODE_GATE 6:5
`define MODE_EN 7
`define MODE_REF_RST 8
`define RG_MSB 17
`define RG_DIV 15:0
`define RG_EN 16
`define RG_PIN 17
`define RST_ZERO 32'h0000_0000
`define DIV16_LAST 4'hF

`endif

// >>> core/timer_quad_pkg.sv
package timer_quad_pkg;
  // Count source of one timer
  typedef enum logic [1:0] {SRC_PARTNER, SRC_SYSCLK, SRC_DIV16, SRC_PIN} src_sel_t;
  // External gate usage
  typedef enum logic [1:0] {GATE_OFF, GATE_LEVEL, GATE_RESTART, GATE_SPARE} gate_mode_t;
  // Capture edge choice
  typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_sel_t;
endpackage

// >>> core/timer_unit.sv
`timescale 1ns/100ps
module timer_unit #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Count control
  input wire logic tick,
  input wire logic run,
  input wire logic restart,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic [WIDTH-1:0] ref_val,
  input wire logic out_toggle,
  input wire logic ref_restart,
  // Capture
  input wire logic cap_in,
  input wire timer_quad_pkg::edge_sel_t cap_edge,
  // Results
  output logic [WIDTH-1:0] count_ff,
  output logic [WIDTH-1:0] cap_ff,
  output logic match_ff,
  output logic cap_evt_ff,
  output logic out_ff
);
  import timer_quad_pkg::*;
  logic cap_prev_ff;
  logic hit;
  logic cap_hit;

  assign hit = run & tick & (count_ff == ref_val);

  // Edge choice for the capture input
  always_comb begin
    case (cap_edge)
      EDGE_RISE: cap_hit = cap_in & ~cap_prev_ff;
      EDGE_FALL: cap_hit = ~cap_in & cap_prev_ff;
      EDGE_BOTH: cap_hit = cap_in ^ cap_prev_ff;
      default: cap_hit = 1'b0;
    endcase
  end

  // Counter; restart beats a software load, which beats counting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
    end else if (restart) begin
      count_ff <= '0;
    end else if (load) begin
      count_ff <= load_val;
    end else if (run && tick) begin
      count_ff <= (hit && ref_restart) ? '0 : count_ff + 1'b1;
    end
  end

  // Match pulse feeds the partner timer and the event logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= hit;
    end
  end

  // Output idles high; a match gives one low cycle or flips the level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_ff <= 1'b1;
    end else if (hit) begin
      out_ff <= out_toggle ? ~out_ff : 1'b0;
    end else if (!out_toggle) begin
      out_ff <= 1'b1;
    end
  end

  // Capture latches the running count on the chosen edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_prev_ff <= 1'b0;
      cap_ff <= '0;
      cap_evt_ff <= 1'b0;
    end else begin
      cap_prev_ff <= cap_in;
      cap_evt_ff <= cap_hit;
      if (cap_hit) begin
        cap_ff <= count_ff;
      end
    end
  end
endmodule // timer_unit

// >>> verif/pin_partner.sv
`timescale 1ns/100ps
module pin_partner (
  // Clock
  input wire logic clk,
  // Pins into the block
  output logic [3:0] ext_in,
  output logic gate_a_n,
  output logic gate_b_n,
  output logic [9:0] clk_in,
  output logic ded_clk
);
  // ****************************************
  // External pins; clocks stand still between bursts
  // ****************************************
  initial begin
    ext_in = 4'h0;
    gate_a_n = 1'b1;
    gate_b_n = 1'b1;
    clk_in = 10'h000;
    ded_clk = 1'b0;
  end
  // One clock pulse, two cycles high and two low; index 10 is the dedicated pin
  task automatic clk_pulse(input int i);
    repeat (2) begin
      @(posedge clk);
      if (i < 10) clk_in[i] <= ~clk_in[i];
      else ded_clk <= ~ded_clk;
      @(posedge clk);
    end
  endtask
  task automatic set_ext(input logic [3:0] v);
    @(posedge clk);
    ext_in <= v;
  endtask
  task automatic set_gate(input logic a, input logic b);
    @(posedge clk);
    gate_a_n <= a;
    gate_b_n <= b;
  endtask
endmodule // pin_partner

// >>> verif/test_comm_module_timer_quad.sv
`timescale 1ns/100ps
module test_comm_module_timer_quad;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, gate_a_n, gate_b_n, ded, irq, sys_tick, p0, er_q;
  logic [7:0] paddr, rg_out, rg_oe_n;
  logic [31:0] pwdata, prdata, rd_q, d;
  logic [3:0] ext_in, m_out, m_oe_n, c_tick;
  logic [9:0] clk_in;
  logic [7:0] ra[10] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h80};
  int err_count, n_tests, chg0, st, lows[4], tk[2];
  comm_module_timer_quad DUT (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TIMER_EXT_IN(ext_in), .GATE_PIN_A(gate_a_n), .GATE_PIN_B(gate_b_n), .CLOCK_IN(clk_in),
    .DEDICATED_TIMER_CLOCK_PIN(ded), .TIMER_MATCH_OUT(m_out), .TIMER_MATCH_OUT_OE_N(m_oe_n),
    .RATE_GEN_OUT(rg_out), .RATE_GEN_OUT_OE_N(rg_oe_n), .CTRL_CLK_TICK(c_tick),
    .SYS_TMR_TICK(sys_tick), .IRQ(irq));
  pin_partner pins (.clk(clk), .ext_in(ext_in), .gate_a_n(gate_a_n), .gate_b_n(gate_b_n),
    .clk_in(clk_in), .ded_clk(ded));
  // ****************************************
  // Clock, monitors and bus tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Sampled mid-cycle so the counts never race the drivers
  always @(negedge clk) begin
    for (int i = 0; i < 4; i++) lows[i] += int'(m_out[i] === 1'b0);
    chg0 += int'(m_out[0] !== p0);
    p0 = m_out[0];
    tk[0] += int'(c_tick[0] === 1'b1);
    tk[1] += int'(c_tick[1] === 1'b1);
    st += int'(sys_tick === 1'b1);
  end
  task automatic clr;
    lows = '{default: 0};
    tk = '{default: 0};
    chg0 = 0;
    st = 0;
  endtask
  // One transfer and one idle cycle, so no signal is assigned twice in a step
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    if (n >= 16) err_count++;
    rd_q = prdata;
    er_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(a, 1'b1, wd);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  // Count advance of one counter over n+3 edges
  task automatic span(input logic [7:0] a, input int n);
    logic [31:0] c0;
    xfer(a, 1'b0, 32'h0);
    c0 = rd_q;
    repeat (n) @(posedge clk);
    xfer(a, 1'b0, 32'h0);
    d = (rd_q - c0) & 32'h0000_FFFF;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    int x;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      xfer(ra[i], 1'b0, 32'h0);
      chk("reset value", 32'h0, rd_q);
    end
    chk("out idle", 32'hF, m_out);
    chk("out released", 32'hF, m_oe_n);
    xfer(8'h0C, 1'b0, 32'h0);
    chk("unmapped error", 32'h1, er_q);
    wr(8'h10, 32'hFF);
    xfer(8'h10, 1'b0, 32'h0);
    chk("status read only", 32'h0, rd_q);
    // match pulse per timer, period ref+1
    wr(8'h04, 32'hF);
    for (int t = 0; t < 4; t++) begin
      wr(8'(8'h44 + 16 * t), t + 2);
      wr(8'(8'h40 + 16 * t), 32'h181);
    end
    repeat (10) @(posedge clk);
    clr();
    repeat (60) @(posedge clk);
    for (int t = 0; t < 4; t++) chk("pulse count", 60 / (t + 3), lows[t]);
    chk("out driven", 32'h0, m_oe_n);
    wr(8'h40, 32'h185);
    repeat (10) @(posedge clk);
    clr();
    repeat (30) @(posedge clk);
    chk("toggle count", 32'd10, chg0);
    // capture edges, irq masked for the falling-only choice
    wr(8'h04, 32'h20);
    for (int e = 1; e < 4; e++) begin
      wr(8'h18, (e == 2) ? 32'h0 : 32'h20);
      wr(8'h50, 32'h81 | (e << 3));
      for (int v = 1; v >= 0; v--) begin
        wr(8'h14, 32'hFF);
        pins.set_ext({2'h0, v[0], 1'b0});
        repeat (6) @(posedge clk);
        xfer(8'h10, 1'b0, 32'h0);
        x = v ? (e & 1) : (e >> 1);
        chk("capture flag", x << 5, rd_q & 32'h20);
        chk("irq level", x & (e != 2), irq);
      end
    end
    // disabled input pin sees no edge
    wr(8'h04, 32'h0);
    wr(8'h14, 32'hFF);
    pins.set_ext(4'h2);
    repeat (6) @(posedge clk);
    xfer(8'h10, 1'b0, 32'h0);
    chk("input off", 32'h0, rd_q & 32'h20);
    // divided clock, partner and pin sources
    wr(8'h40, 32'h82);
    span(8'h48, 157);
    chk("div16 count", 32'd10, d);
    wr(8'h40, 32'h181);
    wr(8'h48, 32'h0);
    wr(8'h50, 32'h80);
    span(8'h58, 147);
    chk("cascade count", 32'd50, d);
    wr(8'h04, 32'h80);
    wr(8'h70, 32'h83);
    xfer(8'h78, 1'b0, 32'h0);
    d = rd_q;
    repeat (3) begin
      pins.set_ext(4'h8);
      pins.set_ext(4'h0);
    end
    repeat (4) @(posedge clk);
    xfer(8'h78, 1'b0, 32'h0);
    chk("pin count", 32'd3, (rd_q - d) & 32'hFFFF);
    // gate pin A on timer 0, pin B on timer 2
    for (int k = 0; k < 4; k += 2) begin
      wr(8'h00, 32'h1 << k);
      wr(8'h04, 32'h300);
      wr(8'(8'h40 + 16 * k), 32'hA1);
      span(8'(8'h48 + 16 * k), 7);
      chk("gate high", 32'h0, d);
      pins.set_gate(k != 0, k == 0);
      repeat (3) @(posedge clk);
      span(8'(8'h48 + 16 * k), 7);
      chk("gate low", 32'd10, d);
      pins.set_gate(1'b1, 1'b1);
    end
    // generator 1 to route 0, clock pin 2 to route 1
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h5000);
    wr(8'h08, 32'h4A);
    wr(8'h80, 32'h3_0003);
    clr();
    repeat (84) @(posedge clk);
    chk("routed ticks", 32'd20, tk[0]);
    chk("system ticks", 32'd20, st);
    chk("rate pin on", 32'h0, rg_oe_n[0]);
    repeat (3) pins.clk_pulse(2);
    repeat (4) @(posedge clk);
    chk("clock pin ticks", 32'd3, tk[1]);
    // fifth clock input feeds generator 1
    wr(8'h00, 32'h100);
    wr(8'h80, 32'h3_0000);
    repeat (4) @(posedge clk);
    clr();
    repeat (20) @(posedge clk);
    chk("fifth idle", 32'h0, tk[0]);
    repeat (4) pins.clk_pulse(4);
    repeat (4) @(posedge clk);
    chk("fifth ticks", 32'd4, st);
    // dedicated pin cuts generator 1 from system timers
    wr(8'h00, 32'h200);
    repeat (4) @(posedge clk);
    clr();
    repeat (20) @(posedge clk);
    chk("generator cut", 32'h0, st);
    repeat (3) pins.clk_pulse(10);
    repeat (4) @(posedge clk);
    chk("dedicated ticks", 32'd3, st);
    give_verdict();
  end
endmodule // test_comm_module_timer_quad

// >>> verif/timer_quad_properties.sv
`timescale 1ns/100ps
module timer_quad_properties (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Pins and events
  input wire logic DEDICATED_TIMER_CLOCK_PIN,
  input wire logic [3:0] TIMER_MATCH_OUT,
  input wire logic [3:0] TIMER_MATCH_OUT_OE_N,
  input wire logic [7:0] RATE_GEN_OUT,
  input wire logic [7:0] RATE_GEN_OUT_OE_N,
  input wire logic SYS_TMR_TICK,
  input wire logic IRQ
);
  logic wr_ok;
  logic tog_ff;
  logic [31:0] gcr_ff, port_ff, en_ff;
  logic [3:0] quiet_ff;
  assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  // Shadow of settings, so pin checks know the configuration
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      gcr_ff <= 32'h0;
      port_ff <= 32'h0;
      en_ff <= 32'h0;
      tog_ff <= 1'b0;
    end else if (wr_ok) begin
      if (PADDR == 8'h00) gcr_ff <= PWDATA;
      if (PADDR == 8'h04) port_ff <= PWDATA;
      if (PADDR == 8'h18) en_ff <= PWDATA;
      if (PADDR == 8'h40) tog_ff <= PWDATA[2];
    end
  end
  // Cycles with dedicated pin selected and still; saturates
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) quiet_ff <= 4'h0;
    else if (!gcr_ff[9] || !$stable(DEDICATED_TIMER_CLOCK_PIN)) quiet_ff <= 4'h0;
    else if (quiet_ff != 4'h8) quiet_ff <= quiet_ff + 4'h1;
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence access_s;
    PSEL && PENABLE && PREADY;
  endsequence
  apb_answer_a:
    assert property (setup_s |=> PREADY) else $error("no ready after setup");
  ready_once_a:
    assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
  err_with_ready_a:
    assert property (PSLVERR |-> PREADY) else $error("error without ready");
  timer_mapped_a:
    assert property (setup_s ##0 PADDR[7:6] == 2'h1 |=> !PSLVERR) else $error("timer space refused");
  write_data_zero_a:
    assert property (access_s ##0 PWRITE |-> PRDATA == 32'h0) else $error("read data on write");
  out_release_a:
    assert property (&(TIMER_MATCH_OUT_OE_N | $past(port_ff[3:0]))) else $error("disabled out driven");
  rate_pin_quiet_a:
    assert property ((RATE_GEN_OUT & RATE_GEN_OUT_OE_N) == 8'h00) else $error("rate out while off");
  sys_tick_cut_a:
    assert property (quiet_ff > 4'h5 |-> !SYS_TMR_TICK) else $error("generator reaches system timers");
  irq_masked_a:
    assert property (en_ff == 32'h0 && $past(en_ff) == 32'h0 |-> !IRQ) else $error("irq while masked");
  pulse_width_a:
    assert property ($fell(TIMER_MATCH_OUT[0]) && !tog_ff && !$past(tog_ff) && !$past(tog_ff, 2)
      |=> TIMER_MATCH_OUT[0]) else $error("pulse wider than one cycle");
endmodule // timer_quad_properties

bind comm_module_timer_quad timer_quad_properties chk (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .DEDICATED_TIMER_CLOCK_PIN(DEDICATED_TIMER_CLOCK_PIN), .TIMER_MATCH_OUT(TIMER_MATCH_OUT),
  .TIMER_MATCH_OUT_OE_N(TIMER_MATCH_OUT_OE_N), .RATE_GEN_OUT(RATE_GEN_OUT),
  .RATE_GEN_OUT_OE_N(RATE_GEN_OUT_OE_N), .SYS_TMR_TICK(SYS_TMR_TICK), .IRQ(IRQ));
